// ---- common/switch_params.svh ----
/*
 * Constants of the eight-channel addressable switch: command codes,
 * register page addresses, field positions, reset values and counts.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef SWITCH_PARAMS_SVH
`define SWITCH_PARAMS_SVH

// Selection commands, the first byte after a bus reset
`define SW_CMD_READ_ROM 8'h33
`define SW_CMD_MATCH_ROM 8'h55
`define SW_CMD_SEARCH_ROM 8'hf0
`define SW_CMD_COND_SEARCH 8'hec
`define SW_CMD_SKIP_ROM 8'hcc
`define SW_CMD_OD_SKIP 8'h3c
`define SW_CMD_OD_MATCH 8'h69
`define SW_CMD_RESUME 8'ha5

// Control commands, accepted once selected
`define SW_CMD_CA_READ 8'hf5
`define SW_CMD_CA_WRITE 8'h5a
`define SW_CMD_RD_REGS 8'hf0
`define SW_CMD_WR_REGS 8'hcc
`define SW_CMD_RST_ACT 8'hc3
`define SW_CONFIRM 8'haa

// Register page addresses
`define SW_ADR_PIN 16'h0088
`define SW_ADR_LATCH 16'h0089
`define SW_ADR_ACT 16'h008a
`define SW_ADR_MASK 16'h008b
`define SW_ADR_POL 16'h008c
`define SW_ADR_CTRL 16'h008d
`define SW_ADR_LAST 16'h008f
`define SW_ADR_ONE 16'h0001

// Control/status fields and reset values
`define SW_ROS_BIT 2
`define SW_PORL_BIT 3
`define SW_CTRL_RST 8'h08
`define SW_ZERO8 8'h00
`define SW_ONES8 8'hff

// Check value and identifier layout
`define SW_CRC_POLY 8'h8c
`define SW_BYTE_LAST 3'h7
`define SW_ROM_LAST 6'h3f
`define SW_BODY_LAST 6'h37
`define SW_CNT_ONE 6'h01
`define SW_PH_LAST 2'h2

`endif

// ---- common/switch_pkg.sv ----
/*
 * Types of the eight-channel addressable switch.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package switch_pkg;
    // Protocol states, Gray coded along select-then-access path
    typedef enum logic [3:0] {
        S_ROM_CMD = 4'h0,
        S_ROM_MATCH = 4'h1,
        S_CTRL_CMD = 4'h3,
        S_CA_WRITE = 4'h2,
        S_CA_READ = 4'h6,
        S_SEND_AA = 4'h7,
        S_REG_ADDR = 4'h5,
        S_REG_READ = 4'h4,
        S_REG_WRITE = 4'hc,
        S_ROM_READ = 4'hd,
        S_ROM_SEARCH = 4'hf,
        S_IDLE = 4'he
    } state_e;
endpackage

// ---- dv/bus_master_model.sv ----
/*
 * Behavioural bus master standing behind the slot front end.
 * Assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
    // Clock
    input wire logic clk,
    // Slot link toward the switch
    output logic bus_reset,
    output logic bus_reset_std,
    output logic slot_valid,
    output logic slot_bit,
    input wire logic ret_bit_q,
    // Report of each byte read back
    output logic [7:0] got_byte,
    output logic got_valid
);
    // Quiet link at time zero
    initial begin
        bus_reset = 1'b0;
        bus_reset_std = 1'b0;
        slot_valid = 1'b0;
        slot_bit = 1'b1;
        got_byte = 8'h00;
        got_valid = 1'b0;
    end

    // Bus reset; a selection byte must follow it
    task automatic bus_rst(input logic std);
        bus_reset <= 1'b1;
        bus_reset_std <= std;
        @(posedge clk);
        bus_reset <= 1'b0;
        bus_reset_std <= ~std;
        @(posedge clk);
    endtask

    // One slot; the reply is taken at the slot edge
    task automatic slot(input logic b, output logic r);
        slot_valid <= 1'b1;
        slot_bit <= b;
        @(posedge clk);
        r = ret_bit_q;
        slot_valid <= 1'b0;
        // Line is not left at the old value between slots
        slot_bit <= ~b;
        // Prompt or slow master: two or three idle edges
        repeat (2 + $urandom_range(1)) @(posedge clk);
    endtask

    // Byte out, least significant bit first
    task automatic send_byte(input logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            slot(d[i], r);
        end
    endtask

    // Byte in, least significant bit first
    task automatic read_byte();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            slot(1'b1, v[i]);
        end
        got_byte <= v;
        got_valid <= 1'b1;
        @(posedge clk);
        got_valid <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench of the switch command layer.
 * Assumes the bus master model drives the slot link.
 */
`timescale 1ns/1ps
`default_nettype none
`include "switch_params.svh"

module tb_top;
    logic clk; // System clock
    logic rstn; // Async reset, active low
    logic ret_bit_q, overdrive_q, rs_in, rs_out_q, rs_oe_q;
    logic bus_reset, bus_reset_std, slot_valid, slot_bit, got_valid;
    logic [7:0] chan_in, chan_out_q, chan_oe_q, got_byte, d, crc;
    logic [63:0] id; // Identifier as the master sends it to match
    logic [7:0] exp_q[$]; // Expected bytes in read order
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    switch_top dut (.clk(clk), .rstn(rstn), .bus_reset(bus_reset),
        .bus_reset_std(bus_reset_std), .slot_valid(slot_valid),
        .slot_bit(slot_bit), .ret_bit_q(ret_bit_q),
        .overdrive_q(overdrive_q), .chan_in(chan_in),
        .chan_out_q(chan_out_q), .chan_oe_q(chan_oe_q), .rs_in(rs_in),
        .rs_out_q(rs_out_q), .rs_oe_q(rs_oe_q));

    bus_master_model m (.clk(clk), .bus_reset(bus_reset),
        .bus_reset_std(bus_reset_std), .slot_valid(slot_valid),
        .slot_bit(slot_bit), .ret_bit_q(ret_bit_q), .got_byte(got_byte),
        .got_valid(got_valid));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare one value
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Reflected check value, zero start, own model
    function automatic logic [7:0] crc8(input logic [55:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            c = ((c[0] ^ v[i]) ? 8'h8c : 8'h00) ^ (c >> 1);
        end
        return c;
    endfunction

    // Read bytes are checked in order of arrival
    always @(posedge clk) begin
        if (got_valid === 1'b1) begin
            check(got_byte, exp_q.pop_front());
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // Select by skip, then send one control command
    task automatic select(input logic [7:0] cmd);
        m.bus_rst(1'b1);
        m.send_byte(`SW_CMD_SKIP_ROM);
        m.send_byte(cmd);
    endtask

    // Channel write of one byte and its inverse
    task automatic chan_write(input logic [7:0] v);
        m.send_byte(v);
        m.send_byte(~v);
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        rs_in = 1'b1;
        void'($urandom(32'h9b7ac228));
        chan_in = 8'($urandom);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Identifier walk must finish before the first bus reset
        repeat (64) @(posedge clk);
        check(chan_oe_q, 8'h00);
        check(chan_out_q | {7'h00, rs_oe_q}, 8'h00);
        // Identifier read
        m.bus_rst(1'b1);
        m.send_byte(`SW_CMD_READ_ROM);
        exp_q = {8'h5e, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        crc = crc8({48'h1, 8'h5e});
        exp_q.push_back(crc);
        repeat (8) m.read_byte();
        // Channel write, pin in reset mode gives no strobe
        d = 8'($urandom);
        select(`SW_CMD_CA_WRITE);
        chan_write(d);
        check(chan_oe_q, ~d);
        check({7'h00, rs_oe_q}, 8'h00);
        exp_q.push_back(`SW_CONFIRM);
        m.read_byte();
        // Low reset input turns all channels off
        rs_in <= 1'b0;
        @(posedge clk);
        rs_in <= 1'b1;
        repeat (2) @(posedge clk);
        check(chan_oe_q, 8'h00);
        // Unknown selection byte leaves control commands refused
        m.bus_rst(1'b1);
        m.send_byte(8'h00);
        m.send_byte(`SW_CMD_CA_WRITE);
        chan_write(8'h0f);
        check(chan_oe_q, 8'h00);
        // Switch the pin to strobe output
        select(`SW_CMD_WR_REGS);
        m.send_byte(8'h8d);
        m.send_byte(8'h00);
        m.send_byte(8'h04);
        d = 8'($urandom);
        select(`SW_CMD_CA_WRITE);
        chan_write(d);
        check(chan_oe_q, ~d);
        check({7'h00, rs_oe_q}, 8'h01);
        exp_q.push_back(`SW_CONFIRM);
        m.read_byte();
        // Reset input ignored while strobing
        rs_in <= 1'b0;
        repeat (2) @(posedge clk);
        rs_in <= 1'b1;
        check(chan_oe_q, ~d);
        // Channel read strobes after the byte
        chan_in <= 8'($urandom);
        @(posedge clk);
        select(`SW_CMD_CA_READ);
        exp_q.push_back(chan_in);
        m.read_byte();
        check({7'h00, rs_oe_q}, 8'h01);
        // Match by identifier; activity clear answers with confirmation
        id = {crc, 48'h1, 8'h5e};
        m.bus_rst(1'b1);
        m.send_byte(`SW_CMD_MATCH_ROM);
        for (int i = 0; i < 8; i++) begin
            m.send_byte(id[8*i +: 8]);
        end
        m.send_byte(`SW_CMD_RST_ACT);
        exp_q.push_back(`SW_CONFIRM);
        m.read_byte();
        // Resume reselects it; latches, then cleared activity read back
        m.bus_rst(1'b1);
        m.send_byte(`SW_CMD_RESUME);
        m.send_byte(`SW_CMD_RD_REGS);
        m.send_byte(8'h89);
        m.send_byte(8'h00);
        exp_q.push_back(d);
        exp_q.push_back(8'h00);
        repeat (2) m.read_byte();
        // Overdrive entry, kept by short reset, left by standard one
        m.bus_rst(1'b1);
        m.send_byte(`SW_CMD_OD_SKIP);
        check({7'h00, overdrive_q}, 8'h01);
        m.bus_rst(1'b0);
        check({7'h00, overdrive_q}, 8'h01);
        m.bus_rst(1'b1);
        check({7'h00, overdrive_q}, 8'h00);
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule

`default_nettype wire

// ---- src/lsb_crc8.sv ----
/*
 * Serial check-value generator, fed least significant bit first.
 * Assumes clr and en are never raised together by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "switch_params.svh"

module lsb_crc8 (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control and data
    input wire logic clr,
    input wire logic en,
    input wire logic din,
    // Running check value
    output logic [7:0] crc_q
);
    logic [7:0] crc_d; // Next check value
    logic fb; // Feedback bit

    // Shift right with reflected polynomial, initial value zero
    always_comb begin
        fb = din ^ crc_q[0];
        crc_d = crc_q;
        if (clr) begin
            crc_d = `SW_ZERO8;
        end else if (en) begin
            crc_d = {1'b0, crc_q[7:1]} ^ (fb ? `SW_CRC_POLY : `SW_ZERO8);
        end
    end

    // Register only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_q <= `SW_ZERO8;
        end else begin
            crc_q <= crc_d;
        end
    end
endmodule
`default_nettype wire

// ---- src/switch_top.sv ----
/*
 * Command layer of an eight-channel addressable open-drain switch.
 * Assumes a slot front end that reports bus resets and one pulse per
 * bus time slot with the bit the master wrote; ret_bit_q is the level
 * the device leaves on the line in a read slot.
 */
// Overview of operation
// - Eight channels: input plus open-drain output
// - Reset/strobe pin function chosen by software
// - Low reset input sets all output latches
// - Strobe after channel-access write and read
// - Pin powers up as reset input
// - 64-bit identifier and 64-bit register page
// - Overdrive command at standard speed enters overdrive
// - Control commands only after successful selection
// - All bytes travel least significant bit first
// - Identifier: family, 48-bit serial, check byte
// - Check polynomial x8+x5+x4+1, zero start
// - Output latches hold last written value until a low reset input sets them
`timescale 1ns/1ps
`default_nettype none
`include "switch_params.svh"

module switch_top #(
    parameter logic [7:0] FAMILY_CODE = 8'h5e, // Arbitrary value
    parameter logic [47:0] SERIAL = 48'h0000_0000_0001 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus slot interface
    input wire logic bus_reset,
    input wire logic bus_reset_std,
    input wire logic slot_valid,
    input wire logic slot_bit,
    output logic ret_bit_q,
    output logic overdrive_q,
    // Channel pins
    input wire logic [7:0] chan_in,
    output logic [7:0] chan_out_q,
    output logic [7:0] chan_oe_q,
    // Reset/strobe pin
    input wire logic rs_in,
    output logic rs_out_q,
    output logic rs_oe_q
);
    switch_pkg::state_e state_q, state_d; // Protocol state
    logic [5:0] cnt_q, cnt_d; // Bit counter within field
    logic [1:0] ph_q, ph_d; // Sub-phase of search and two-byte fields
    logic [7:0] sh_q, sh_d; // Receive shift register
    logic [7:0] tx_q, tx_d; // Byte being sent
    logic [7:0] cmd_q, cmd_d; // Last control command
    logic [7:0] data_q, data_d; // Channel write data awaiting its inverse
    logic [15:0] addr_q, addr_d; // Register page address
    logic [7:0] latch_q, latch_d; // Channel output latches
    logic [7:0] act_q, act_d; // Activity latches
    logic [7:0] prev_q; // Last sampled channel level
    logic [7:0] mask_q, mask_d, pol_q, pol_d, ctrl_q, ctrl_d; // Page regs
    logic od_d, resume_q, resume_d, access_strobe_output_d, ret_d; // Flags
    logic [5:0] init_q; // Identifier check walk index
    logic rom_ok_q; // Check value ready
    logic [7:0] crc_q; // Check value of identifier body
    logic [7:0] rx; // Byte as it stands after this slot
    logic byte_end, act_clr, ros;
    logic [63:0] rom; // Identifier, bit 0 sent first

    assign rom = {crc_q, SERIAL, FAMILY_CODE};
    assign ros = ctrl_q[`SW_ROS_BIT];
    assign rx = {slot_bit, sh_q[7:1]};
    assign byte_end = cnt_q[2:0] == `SW_BYTE_LAST;

    // Check value of the 56-bit body, walked once after reset
    lsb_crc8 u_crc (
        .clk(clk),
        .rstn(rstn),
        .clr(1'b0),
        .en(!rom_ok_q),
        .din(rom[init_q]),
        .crc_q(crc_q)
    );

    // Register page read decode; unmapped bytes read as all ones
    function automatic logic [7:0] rd_reg(input logic [15:0] a);
        case (a)
            `SW_ADR_PIN: rd_reg = chan_in;
            `SW_ADR_LATCH: rd_reg = latch_q;
            `SW_ADR_ACT: rd_reg = act_q;
            `SW_ADR_MASK: rd_reg = mask_q;
            `SW_ADR_POL: rd_reg = pol_q;
            `SW_ADR_CTRL: rd_reg = ctrl_q;
            default: rd_reg = `SW_ONES8;
        endcase
    endfunction

    // Next-state logic for protocol, latches and page registers
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ph_d = ph_q;
        sh_d = sh_q;
        tx_d = tx_q;
        cmd_d = cmd_q;
        data_d = data_q;
        addr_d = addr_q;
        latch_d = latch_q;
        mask_d = mask_q;
        pol_d = pol_q;
        ctrl_d = ctrl_q;
        od_d = overdrive_q;
        resume_d = resume_q;
        access_strobe_output_d = rs_oe_q;
        act_clr = 1'b0;
        // A strobe lasts until the next slot, never longer
        if (rs_oe_q && slot_valid) begin
            access_strobe_output_d = 1'b0;
        end
        // Slots during the check walk are ignored; it takes 56 cycles
        if (slot_valid && rom_ok_q) begin
            cnt_d = cnt_q + `SW_CNT_ONE;
            sh_d = rx;
            case (state_q)
                switch_pkg::S_ROM_CMD: begin
                    if (byte_end) begin
                        cnt_d = '0;
                        state_d = switch_pkg::S_IDLE;
                        case (rx)
                            `SW_CMD_READ_ROM: begin
                                state_d = switch_pkg::S_ROM_READ;
                            end
                            `SW_CMD_MATCH_ROM, `SW_CMD_OD_MATCH: begin
                                state_d = switch_pkg::S_ROM_MATCH;
                            end
                            `SW_CMD_SKIP_ROM, `SW_CMD_OD_SKIP: begin
                                state_d = switch_pkg::S_CTRL_CMD;
                                resume_d = 1'b0;
                            end
                            `SW_CMD_SEARCH_ROM: begin
                                state_d = switch_pkg::S_ROM_SEARCH;
                                ph_d = '0;
                            end
                            `SW_CMD_RESUME: begin
                                if (resume_q) begin
                                    state_d = switch_pkg::S_CTRL_CMD;
                                end
                            end
                            // Conditional search: this block never joins
                            default: resume_d = 1'b0;
                        endcase
                        if (rx == `SW_CMD_OD_SKIP || rx == `SW_CMD_OD_MATCH) begin
                            od_d = 1'b1;
                        end
                    end
                end
                switch_pkg::S_ROM_READ: begin
                    if (cnt_q == `SW_ROM_LAST) begin
                        state_d = switch_pkg::S_CTRL_CMD;
                    end
                end
                switch_pkg::S_ROM_MATCH: begin
                    if (slot_bit != rom[cnt_q]) begin
                        state_d = switch_pkg::S_IDLE;
                        resume_d = 1'b0;
                    end else if (cnt_q == `SW_ROM_LAST) begin
                        state_d = switch_pkg::S_CTRL_CMD;
                        resume_d = 1'b1;
                    end
                end
                switch_pkg::S_ROM_SEARCH: begin
                    // Bit, its complement, then the master's choice
                    ph_d = ph_q + 2'h1;
                    cnt_d = cnt_q;
                    if (ph_q == `SW_PH_LAST) begin
                        ph_d = '0;
                        cnt_d = cnt_q + `SW_CNT_ONE;
                        if (slot_bit != rom[cnt_q]) begin
                            state_d = switch_pkg::S_IDLE;
                            resume_d = 1'b0;
                        end else if (cnt_q == `SW_ROM_LAST) begin
                            state_d = switch_pkg::S_CTRL_CMD;
                            resume_d = 1'b1;
                        end
                    end
                end
                switch_pkg::S_CTRL_CMD: begin
                    if (byte_end) begin
                        cmd_d = rx;
                        cnt_d = '0;
                        ph_d = '0;
                        state_d = switch_pkg::S_IDLE;
                        case (rx)
                            `SW_CMD_CA_READ: begin
                                state_d = switch_pkg::S_CA_READ;
                                tx_d = chan_in;
                            end
                            `SW_CMD_CA_WRITE: begin
                                state_d = switch_pkg::S_CA_WRITE;
                            end
                            `SW_CMD_RD_REGS, `SW_CMD_WR_REGS: begin
                                state_d = switch_pkg::S_REG_ADDR;
                            end
                            `SW_CMD_RST_ACT: begin
                                state_d = switch_pkg::S_SEND_AA;
                                tx_d = `SW_CONFIRM;
                                act_clr = 1'b1;
                            end
                            default: state_d = switch_pkg::S_IDLE;
                        endcase
                    end
                end
                switch_pkg::S_CA_READ: begin
                    if (byte_end) begin
                        tx_d = chan_in;
                        access_strobe_output_d = ros;
                    end
                end
                switch_pkg::S_CA_WRITE: begin
                    if (byte_end && ph_q == 2'h0) begin
                        data_d = rx;
                        ph_d = 2'h1;
                    end else if (byte_end) begin
                        ph_d = '0;
                        state_d = switch_pkg::S_IDLE;
                        // Only a byte followed by its inverse is applied
                        if (rx == ~data_q) begin
                            latch_d = data_q;
                            access_strobe_output_d = ros;
                            state_d = switch_pkg::S_SEND_AA;
                            tx_d = `SW_CONFIRM;
                        end
                    end
                end
                switch_pkg::S_SEND_AA: begin
                    if (byte_end && cmd_q == `SW_CMD_CA_WRITE) begin
                        state_d = switch_pkg::S_CA_WRITE;
                    end
                end
                switch_pkg::S_REG_ADDR: begin
                    if (byte_end) begin
                        addr_d = {rx, addr_q[15:8]};
                        ph_d = 2'h1;
                        if (ph_q == 2'h1) begin
                            ph_d = '0;
                            tx_d = rd_reg(addr_d);
                            state_d = (cmd_q == `SW_CMD_RD_REGS) ?
                                switch_pkg::S_REG_READ :
                                switch_pkg::S_REG_WRITE;
                        end
                    end
                end
                switch_pkg::S_REG_READ: begin
                    if (byte_end) begin
                        addr_d = addr_q + `SW_ADR_ONE;
                        tx_d = rd_reg(addr_d);
                    end
                end
                switch_pkg::S_REG_WRITE: begin
                    if (byte_end) begin
                        addr_d = addr_q + `SW_ADR_ONE;
                        case (addr_q)
                            `SW_ADR_MASK: mask_d = rx;
                            `SW_ADR_POL: pol_d = rx;
                            // Power-on flag clears by writing a one
                            `SW_ADR_CTRL: ctrl_d = {4'h0,
                                ctrl_q[`SW_PORL_BIT] & ~rx[`SW_PORL_BIT],
                                rx[2:0]};
                            default: addr_d = addr_q + `SW_ADR_ONE;
                        endcase
                    end
                end
                default: state_d = switch_pkg::S_IDLE;
            endcase
        end
        // Reset input wins over a channel write in the same cycle
        if (!ros && !rs_in) begin
            latch_d = `SW_ONES8;
            act_clr = 1'b1;
        end
        // Bus reset restarts selection; a standard one leaves overdrive
        if (bus_reset) begin
            state_d = switch_pkg::S_ROM_CMD;
            cnt_d = '0;
            ph_d = '0;
            if (bus_reset_std) begin
                od_d = 1'b0;
            end
        end
        // New activity wins over a clear in the same cycle
        act_d = (act_clr ? `SW_ZERO8 : act_q) | (chan_in ^ prev_q);
        // Level for the next read slot; a one releases the line
        case (state_d)
            switch_pkg::S_ROM_READ: ret_d = rom[cnt_d];
            switch_pkg::S_ROM_SEARCH: ret_d = (ph_d == 2'h0) ? rom[cnt_d] :
                (ph_d == 2'h1) ? ~rom[cnt_d] : 1'b1;
            switch_pkg::S_CA_READ, switch_pkg::S_SEND_AA,
            switch_pkg::S_REG_READ: ret_d = tx_d[cnt_d[2:0]];
            default: ret_d = 1'b1;
        endcase
    end

    // Registers only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= switch_pkg::S_IDLE;
            cnt_q <= '0;
            ph_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            cmd_q <= '0;
            data_q <= '0;
            addr_q <= '0;
            latch_q <= `SW_ONES8;
            act_q <= '0;
            // Released pins idle high; a zero here would fake activity
            prev_q <= `SW_ONES8;
            mask_q <= '0;
            pol_q <= '0;
            ctrl_q <= `SW_CTRL_RST;
            overdrive_q <= 1'b0;
            resume_q <= 1'b0;
            init_q <= '0;
            rom_ok_q <= 1'b0;
            ret_bit_q <= 1'b1;
            chan_out_q <= '0;
            chan_oe_q <= '0;
            rs_out_q <= 1'b0;
            rs_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ph_q <= ph_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            cmd_q <= cmd_d;
            data_q <= data_d;
            addr_q <= addr_d;
            latch_q <= latch_d;
            act_q <= act_d;
            prev_q <= chan_in;
            mask_q <= mask_d;
            pol_q <= pol_d;
            ctrl_q <= ctrl_d;
            overdrive_q <= od_d;
            resume_q <= resume_d;
            init_q <= rom_ok_q ? init_q : init_q + `SW_CNT_ONE;
            rom_ok_q <= rom_ok_q | (init_q == `SW_BODY_LAST);
            ret_bit_q <= ret_d;
            chan_out_q <= '0;
            chan_oe_q <= ~latch_d;
            rs_out_q <= 1'b0;
            rs_oe_q <= access_strobe_output_d;
        end
    end

    od_enter_a: assert property (@(posedge clk) disable iff (!rstn)
        (slot_valid && rom_ok_q && !bus_reset && byte_end
        && state_q == switch_pkg::S_ROM_CMD && rx == `SW_CMD_OD_SKIP)
        |=> overdrive_q && state_q == switch_pkg::S_CTRL_CMD)
        else $error("overdrive skip did not enter overdrive");
    rst_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        (!ros && !rs_in) |=> latch_q == `SW_ONES8 && chan_oe_q == 8'h00
        && act_q == ($past(chan_in) ^ $past(prev_q)))
        else $error("reset input did not turn channels off");
    strobe_len_a: assert property (@(posedge clk) disable iff (!rstn)
        (rs_oe_q && slot_valid) |=> !rs_oe_q)
        else $error("strobe outlasted one slot");
    strobe_ros_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rs_oe_q) |-> $past(ros) && ($past(state_q) ==
        switch_pkg::S_CA_READ || $past(state_q) == switch_pkg::S_CA_WRITE))
        else $error("strobe without access or in reset mode");
    chan_drive_a: assert property (@(posedge clk) disable iff (!rstn)
        chan_oe_q == ~latch_q && chan_out_q == 8'h00)
        else $error("channel drive does not follow latch");
    ctrl_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == switch_pkg::S_CTRL_CMD && $past(state_q) !=
        switch_pkg::S_CTRL_CMD) |-> $past(state_q) inside
        {switch_pkg::S_ROM_CMD, switch_pkg::S_ROM_READ,
        switch_pkg::S_ROM_MATCH, switch_pkg::S_ROM_SEARCH})
        else $error("control command entered without selection");
    latch_src_a: assert property (@(posedge clk) disable iff (!rstn)
        (latch_q != $past(latch_q) && $past(ros || rs_in)) |->
        $past(state_q) == switch_pkg::S_CA_WRITE && latch_q == $past(data_q))
        else $error("output latch changed without channel write");
    crc_walk_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rom_ok_q) |-> $past(init_q) == `SW_BODY_LAST)
        else $error("check value walk length wrong");
    lsb_rom_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == switch_pkg::S_ROM_READ) |-> ret_bit_q == rom[cnt_q])
        else $error("identifier bit out of order");
endmodule
`default_nettype wire
